/* File: core/ubtx_defs.svh */
// Register offsets, field positions, reset values and bit timing for the UART transmitter
`ifndef UBTX_DEFS_SVH
`define UBTX_DEFS_SVH
`define UBTX_ADDR_TX_HOLD 8'h00
`define UBTX_ADDR_IRQ_EN 8'h04
`define UBTX_ADDR_IRQ_SRC 8'h08
`define UBTX_ADDR_FIFO_CTL 8'h0c
`define UBTX_ADDR_LINE_CFG 8'h10
`define UBTX_ADDR_LINE_STAT 8'h14
`define UBTX_ADDR_MODEM_CTL 8'h18
`define UBTX_ADDR_DIV_LOW 8'h1c
`define UBTX_ADDR_DIV_HIGH 8'h20
`define UBTX_ADDR_TX_TRIG 8'h24
`define UBTX_ADDR_NONE 8'hff
`define UBTX_LSR_THR_EMPTY 5
`define UBTX_LSR_TSR_EMPTY 6
`define UBTX_IRQ_TX_EMPTY 1
`define UBTX_IRQ_TSR_DONE 2
`define UBTX_FCR_FIFO_EN 0
`define UBTX_MCR_PRESCALE 7
`define UBTX_CFG_TWO_STOP 2
`define UBTX_CFG_PAR_EN 3
`define UBTX_CFG_PAR_EVEN 4
`define UBTX_CFG_EIGHT_X 5
`define UBTX_CFG_RST 6'h03
`define UBTX_DIVISOR_LOW_RST 8'h01
`define UBTX_DIVISOR_HIGH_RST 8'h00
`define UBTX_TRIG_RST 7'h10
`define UBTX_LAST_TICK_16X 4'hf
`define UBTX_LAST_TICK_8X 4'h7
`define UBTX_FIFO_DEPTH 7'h40
`define UBTX_PRESCALE_LAST 2'h3
`endif

/* File: core/ubtx_pkg.sv */
// Types shared by the UART transmitter modules
package ubtx_pkg;
  typedef enum logic [4:0] {
    UBTX_IDLE = 5'b00001,
    UBTX_START = 5'b00010,
    UBTX_DATA = 5'b00100,
    UBTX_PARITY = 5'b01000,
    UBTX_STOP = 5'b10000
  } ubtx_tx_state_t;

  typedef struct packed {
    logic [1:0] pre_cnt;
    logic [15:0] div_cnt;
    logic tick;
  } ubtx_baud_state_t;

  typedef struct packed {
    logic [63:0][7:0] mem;
    logic [5:0] wr_ptr;
    logic [5:0] rd_ptr;
    logic [6:0] count;
  } ubtx_fifo_state_t;

  typedef struct packed {
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [31:0] hrdata;
    logic hready;
    logic [7:0] irq_enable_reg;
    logic [7:0] irq_source_reg;
    logic fifo_en;
    logic [5:0] line_cfg;
    logic [7:0] modem_control_reg;
    logic [7:0] div_lo;
    logic [7:0] div_hi;
    logic [6:0] trig;
    logic div_load;
    logic [7:0] hold_byte;
    logic hold_full;
    logic [7:0] shifter;
    logic parity_acc;
    ubtx_tx_state_t tx_state;
    logic [3:0] tick_cnt;
    logic [2:0] bit_cnt;
    logic stop_cnt;
    logic txd;
    logic irq;
    logic below_trig;
  } ubtx_top_state_t;
endpackage

/* File: core/ubtx_baud_gen.sv */
// Prescaler and 16-bit divisor producing the 16X/8X sampling tick
`timescale 1ns/1ps
`include "ubtx_defs.svh"
module ubtx_baud_gen import ubtx_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic prescale_by4,
  input wire logic [15:0] divisor,
  input wire logic reload,
  output logic sample_tick
);
  ubtx_baud_state_t s_reg;
  ubtx_baud_state_t s_next;
  logic pre_tick;

  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    pre_tick = !prescale_by4 || (s_reg.pre_cnt == `UBTX_PRESCALE_LAST);
    s_next.pre_cnt = s_reg.pre_cnt + 2'h1;
    if (reload) begin
      s_next.pre_cnt = 2'h0;
      s_next.div_cnt = divisor;
    end else if (pre_tick) begin
      if (s_reg.div_cnt <= 16'h0001) begin
        s_next.div_cnt = divisor;
        s_next.tick = 1'b1;
      end else begin
        s_next.div_cnt = s_reg.div_cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sample_tick = s_reg.tick;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_divisor_reload: assert property (reload |=> s_reg.div_cnt == $past(divisor))
    else $error("divisor not reloaded after write");
  a_prescale_four: assert property (s_next.tick && prescale_by4 && !reload |-> s_reg.pre_cnt == 2'h3)
    else $error("tick off the divide-by-4 phase");
endmodule

/* File: core/ubtx_tx_fifo.sv */
// 64-byte transmit FIFO held in flip-flops
`timescale 1ns/1ps
`include "ubtx_defs.svh"
module ubtx_tx_fifo import ubtx_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  output logic wr_ready,
  output logic rd_valid,
  output logic [7:0] rd_data,
  input wire logic rd_ready,
  output logic [6:0] level
);
  ubtx_fifo_state_t s_reg;
  ubtx_fifo_state_t s_next;
  logic push;
  logic pop;

  always_comb begin
    s_next = s_reg;
    push = wr_valid && (s_reg.count != `UBTX_FIFO_DEPTH);
    pop = rd_ready && (s_reg.count != 7'h00);
    if (push) begin
      s_next.mem[s_reg.wr_ptr] = wr_data;
      s_next.wr_ptr = s_reg.wr_ptr + 6'h01;
    end
    if (pop) begin
      s_next.rd_ptr = s_reg.rd_ptr + 6'h01;
    end
    if (push && !pop) begin
      s_next.count = s_reg.count + 7'h01;
    end else if (pop && !push) begin
      s_next.count = s_reg.count - 7'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wr_ready = s_reg.count != `UBTX_FIFO_DEPTH;
  assign rd_valid = s_reg.count != 7'h00;
  assign rd_data = s_reg.mem[s_reg.rd_ptr];
  assign level = s_reg.count;
endmodule

/* File: core/ubtx_top.sv */
// UART channel baud generator and transmitter with AHB-Lite register slave
//
// Overview of operation
// - Prescaler divides input clock by one or four
// - Sixteen-bit divisor yields 16X or 8X tick
// - Sampling tick drives transmitter and sample_tick output
// - Divisor set for 16X or 8X sampling
// - Divisor split into high and low bytes
// - FIFO, holding byte and shifter present
// - Holding byte fed from host or FIFO
// - Bit lasts 16 or 8 ticks
// - Start, data, optional parity, stop bits
// - Data sent least significant bit first
// - Holding writes push FIFO when enabled
// - Holding empty set on shifter load
// - Holding empty raises enabled interrupt bit one with FIFO off
// - Shifter empty flag after final stop
// - FIFO mode empty flag and trigger interrupt
`timescale 1ns/1ps
`include "ubtx_defs.svh"
module ubtx_top import ubtx_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic irq,
  output logic txd,
  output logic sample_tick
);
  ubtx_top_state_t s_reg;
  ubtx_top_state_t s_next;
  logic tick;
  logic fifo_wr_valid;
  logic fifo_wr_ready;
  logic fifo_rd_valid;
  logic [7:0] fifo_rd_data;
  logic fifo_rd_ready;
  logic [6:0] fifo_level;
  logic [7:0] line_stat;
  logic accept;
  logic load;
  logic bit_end;
  logic thr_evt;
  logic tsr_evt;
  logic below;
  logic [3:0] last_tick;
  logic [2:0] last_bit;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  function automatic logic [31:0] read_word(input logic [7:0] addr);
    read_word = 32'h0;
    if (hit(addr, `UBTX_ADDR_IRQ_EN)) read_word = {24'h0, s_reg.irq_enable_reg};
    if (hit(addr, `UBTX_ADDR_IRQ_SRC)) read_word = {24'h0, s_reg.irq_source_reg};
    if (hit(addr, `UBTX_ADDR_FIFO_CTL)) read_word = {31'h0, s_reg.fifo_en};
    if (hit(addr, `UBTX_ADDR_LINE_CFG)) read_word = {26'h0, s_reg.line_cfg};
    if (hit(addr, `UBTX_ADDR_LINE_STAT)) read_word = {24'h0, line_stat};
    if (hit(addr, `UBTX_ADDR_MODEM_CTL)) read_word = {24'h0, s_reg.modem_control_reg};
    if (hit(addr, `UBTX_ADDR_DIV_LOW)) read_word = {24'h0, s_reg.div_lo};
    if (hit(addr, `UBTX_ADDR_DIV_HIGH)) read_word = {24'h0, s_reg.div_hi};
    if (hit(addr, `UBTX_ADDR_TX_TRIG)) read_word = {25'h0, s_reg.trig};
  endfunction

  ubtx_baud_gen u_baud (
    .hclk(hclk),
    .hresetn(hresetn),
    .prescale_by4(s_reg.modem_control_reg[`UBTX_MCR_PRESCALE]),
    .divisor({s_reg.div_hi, s_reg.div_lo}),
    .reload(s_reg.div_load),
    .sample_tick(tick)
  );

  ubtx_tx_fifo u_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_valid(fifo_wr_valid),
    .wr_data(hwdata[7:0]),
    .wr_ready(fifo_wr_ready),
    .rd_valid(fifo_rd_valid),
    .rd_data(fifo_rd_data),
    .rd_ready(fifo_rd_ready),
    .level(fifo_level)
  );

  always_comb begin
    line_stat = 8'h0;
    if (s_reg.fifo_en) begin
      line_stat[`UBTX_LSR_THR_EMPTY] = !fifo_rd_valid && !s_reg.hold_full;
    end else begin
      line_stat[`UBTX_LSR_THR_EMPTY] = !s_reg.hold_full;
    end
    line_stat[`UBTX_LSR_TSR_EMPTY] = (s_reg.tx_state == UBTX_IDLE);
  end

  assign fifo_wr_valid = s_reg.dp_wr && s_reg.fifo_en && hit(s_reg.dp_addr, `UBTX_ADDR_TX_HOLD);
  assign fifo_rd_ready = s_reg.fifo_en && !s_reg.hold_full;

  always_comb begin
    s_next = s_reg;
    s_next.div_load = 1'b0;
    thr_evt = 1'b0;
    tsr_evt = 1'b0;
    load = 1'b0;
    last_tick = s_reg.line_cfg[`UBTX_CFG_EIGHT_X] ? `UBTX_LAST_TICK_8X : `UBTX_LAST_TICK_16X;
    last_bit = {1'b1, s_reg.line_cfg[1:0]};
    bit_end = tick && (s_reg.tick_cnt == last_tick);
    if (bit_end) begin
      s_next.tick_cnt = 4'h0;
    end else if (tick) begin
      s_next.tick_cnt = s_reg.tick_cnt + 4'h1;
    end
    case (s_reg.tx_state)
      UBTX_IDLE: begin
        s_next.txd = 1'b1;
        load = tick && s_reg.hold_full;
      end
      UBTX_START: begin
        if (bit_end) begin
          s_next.tx_state = UBTX_DATA;
          s_next.txd = s_reg.shifter[0];
          s_next.bit_cnt = 3'h0;
          s_next.parity_acc = 1'b0;
        end
      end
      UBTX_DATA: begin
        if (bit_end) begin
          s_next.parity_acc = s_reg.parity_acc ^ s_reg.shifter[0];
          s_next.shifter = {1'b0, s_reg.shifter[7:1]};
          s_next.stop_cnt = s_reg.line_cfg[`UBTX_CFG_TWO_STOP];
          if (s_reg.bit_cnt != last_bit) begin
            s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
            s_next.txd = s_reg.shifter[1];
          end else if (s_reg.line_cfg[`UBTX_CFG_PAR_EN]) begin
            s_next.tx_state = UBTX_PARITY;
            s_next.txd = s_next.parity_acc ^ !s_reg.line_cfg[`UBTX_CFG_PAR_EVEN];
          end else begin
            s_next.tx_state = UBTX_STOP;
            s_next.txd = 1'b1;
          end
        end
      end
      UBTX_PARITY: begin
        if (bit_end) begin
          s_next.tx_state = UBTX_STOP;
          s_next.txd = 1'b1;
        end
      end
      UBTX_STOP: begin
        if (bit_end) begin
          if (s_reg.stop_cnt) begin
            s_next.stop_cnt = 1'b0;
          end else if (s_reg.hold_full) begin
            load = 1'b1;
          end else begin
            s_next.tx_state = UBTX_IDLE;
            tsr_evt = 1'b1;
          end
        end
      end
      default: begin
        s_next.tx_state = UBTX_IDLE;
        s_next.txd = 1'b1;
      end
    endcase
    if (load) begin
      s_next.tx_state = UBTX_START;
      s_next.shifter = s_reg.hold_byte;
      s_next.hold_full = 1'b0;
      s_next.tick_cnt = 4'h0;
      s_next.txd = 1'b0;
      thr_evt = !s_reg.fifo_en;
    end
    if (fifo_rd_ready && fifo_rd_valid) begin
      s_next.hold_byte = fifo_rd_data;
      s_next.hold_full = 1'b1;
    end
    below = fifo_level < s_reg.trig;
    s_next.below_trig = below;
    if (s_reg.fifo_en && below && !s_reg.below_trig) begin
      thr_evt = 1'b1;
    end
    accept = hsel && hready && htrans[1];
    s_next.dp_wr = accept && hwrite;
    s_next.dp_addr = (haddr[31:8] == 24'h0) ? haddr[7:0] : `UBTX_ADDR_NONE;
    s_next.hrdata = (accept && !hwrite) ? read_word(s_next.dp_addr) : 32'h0;
    s_next.hready = 1'b1;
    if (s_reg.dp_wr) begin
      case (s_reg.dp_addr)
        `UBTX_ADDR_TX_HOLD: begin
          if (!s_reg.fifo_en) begin
            s_next.hold_byte = hwdata[7:0];
            s_next.hold_full = 1'b1;
          end
        end
        `UBTX_ADDR_IRQ_EN: s_next.irq_enable_reg = hwdata[7:0];
        `UBTX_ADDR_IRQ_SRC: s_next.irq_source_reg = s_reg.irq_source_reg & ~hwdata[7:0];
        `UBTX_ADDR_FIFO_CTL: s_next.fifo_en = hwdata[`UBTX_FCR_FIFO_EN];
        `UBTX_ADDR_LINE_CFG: s_next.line_cfg = hwdata[5:0];
        `UBTX_ADDR_MODEM_CTL: s_next.modem_control_reg = hwdata[7:0];
        `UBTX_ADDR_DIV_LOW: begin
          s_next.div_lo = hwdata[7:0];
          s_next.div_load = 1'b1;
        end
        `UBTX_ADDR_DIV_HIGH: begin
          s_next.div_hi = hwdata[7:0];
          s_next.div_load = 1'b1;
        end
        `UBTX_ADDR_TX_TRIG: s_next.trig = hwdata[6:0];
        default: begin
        end
      endcase
    end
    if (thr_evt) begin
      s_next.irq_source_reg[`UBTX_IRQ_TX_EMPTY] = 1'b1;
    end
    if (tsr_evt) begin
      s_next.irq_source_reg[`UBTX_IRQ_TSR_DONE] = 1'b1;
    end
    s_next.irq = |(s_next.irq_source_reg & s_next.irq_enable_reg);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
      s_reg.hready <= 1'b1;
      s_reg.line_cfg <= `UBTX_CFG_RST;
      s_reg.div_lo <= `UBTX_DIVISOR_LOW_RST;
      s_reg.div_hi <= `UBTX_DIVISOR_HIGH_RST;
      s_reg.trig <= `UBTX_TRIG_RST;
      s_reg.tx_state <= UBTX_IDLE;
      s_reg.txd <= 1'b1;
      s_reg.below_trig <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign hreadyout = s_reg.hready;
  assign hrdata = s_reg.hrdata;
  assign hresp = 1'b0;
  assign irq = s_reg.irq;
  assign txd = s_reg.txd;
  assign sample_tick = tick;

  logic [4:0] start_ticks;
  logic [7:0] sent_byte;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_ticks <= 5'h0;
      sent_byte <= 8'h0;
    end else if (load) begin
      start_ticks <= 5'h0;
      sent_byte <= s_reg.hold_byte;
    end else if (tick && s_reg.tx_state == UBTX_START) begin
      start_ticks <= start_ticks + 5'h1;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_idle_line_high: assert property (s_reg.tx_state == UBTX_IDLE |-> txd)
    else $error("line not high while idle");
  a_start_bit_low: assert property (load |=> s_reg.tx_state == UBTX_START && !txd)
    else $error("start bit not low after load");
  a_bit_length: assert property ($fell(s_reg.tx_state == UBTX_START) |->
      start_ticks == (s_reg.line_cfg[`UBTX_CFG_EIGHT_X] ? 5'h8 : 5'h10))
    else $error("start bit length wrong");
  a_lsb_first: assert property ($rose(s_reg.tx_state == UBTX_DATA) |-> txd == sent_byte[0])
    else $error("first data bit not bit zero");
  a_thr_empty_irq: assert property (load && !s_reg.fifo_en |=> s_reg.irq_source_reg[`UBTX_IRQ_TX_EMPTY]
      && line_stat[`UBTX_LSR_THR_EMPTY])
    else $error("holding empty not flagged on load");
  a_irq_level: assert property (irq == |(s_reg.irq_source_reg & s_reg.irq_enable_reg))
    else $error("interrupt output disagrees with status");
  a_tsr_empty: assert property (s_reg.tx_state == UBTX_IDLE |-> line_stat[`UBTX_LSR_TSR_EMPTY])
    else $error("shifter empty flag missing");
  a_fifo_push: assert property (fifo_wr_valid && fifo_wr_ready && !fifo_rd_ready
      |=> fifo_level == $past(fifo_level) + 7'h1)
    else $error("holding write not pushed into FIFO");
  a_fifo_empty_flag: assert property (s_reg.fifo_en && fifo_level == 7'h0 && !s_reg.hold_full
      |-> line_stat[`UBTX_LSR_THR_EMPTY])
    else $error("FIFO empty not flagged");
  c_char_sent: cover property (s_reg.tx_state == UBTX_STOP ##1 s_reg.tx_state == UBTX_IDLE);
  c_parity_sent: cover property (s_reg.tx_state == UBTX_PARITY);
  c_irq_raised: cover property ($rose(irq));
  c_fifo_full: cover property (!fifo_wr_ready);
endmodule

/* File: test/ubtx_rx_model.sv */
// Remote serial receiver model that decodes the transmit line
`timescale 1ns/1ps
module ubtx_rx_model (
  input wire logic hclk,
  input wire logic txd,
  input wire logic sample_tick,
  input wire logic [5:0] line_cfg,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rx_fault
);
  int tpb;
  int nbits;

  task automatic ticks(input int k);
    repeat (k) begin
      @(posedge hclk);
      while (sample_tick !== 1'b1) @(posedge hclk);
    end
  endtask

  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    rx_fault = 1'b0;
  end

  // Samples each bit in its middle, counted in sampling ticks
  always begin
    @(negedge txd);
    tpb = line_cfg[5] ? 8 : 16;
    nbits = 5 + line_cfg[1:0];
    ticks(tpb / 2);
    rx_fault = txd;
    rx_byte = 8'h00;
    for (int i = 0; i < nbits; i++) begin
      ticks(tpb);
      rx_byte[i] = txd;
    end
    if (line_cfg[3]) begin
      ticks(tpb);
      rx_fault = rx_fault | (txd !== (^rx_byte ^ !line_cfg[4]));
    end
    repeat (line_cfg[2] ? 2 : 1) begin
      ticks(tpb);
      rx_fault = rx_fault | (txd !== 1'b1);
    end
    rx_valid <= 1'b1;
    @(posedge hclk);
    rx_valid <= 1'b0;
  end
endmodule

/* File: test/tb_ubtx_top.sv */
// Self-checking testbench for the UART baud generator and transmitter
`timescale 1ns/1ps
`include "ubtx_defs.svh"
module tb_ubtx_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic rd_dp = 1'b0;
  logic [5:0] cfg = 6'h03;
  logic [31:0] seed = 32'ha56cb2bf;
  logic hreadyout, hresp, irq, txd, sample_tick, rx_valid, rx_fault;
  logic [31:0] hrdata;
  logic [7:0] rx_byte;
  logic [31:0] exp_rd[$];
  logic [7:0] exp_rx[$];
  int error_cnt = 0;
  int num_checks = 0;
  localparam logic [7:0] RA[10] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
    8'h20, 8'h24, 8'h00};
  localparam logic [7:0] RV[10] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h60, 8'h00, 8'h01,
    8'h00, 8'h10, 8'h00};

  always #50 hclk = ~hclk;

  ubtx_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq), .txd(txd),
    .sample_tick(sample_tick));

  ubtx_rx_model rx_u (.hclk(hclk), .txd(txd), .sample_tick(sample_tick), .line_cfg(cfg),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_fault(rx_fault));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("Checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, input logic c);
    int n;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (n >= 64) error_cnt++;
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp <= c;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (n >= 64) error_cnt++;
    rd_dp <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    bus(a, 1'b0, 32'h0, 1'b1);
  endtask

  task automatic tick_gap(input int e);
    int n;
    repeat (2) begin
      n = 0;
      do begin
        @(posedge hclk);
        n++;
      end while (sample_tick !== 1'b1 && n < 70000);
    end
    check("tick_gap", n, e);
  endtask

  task automatic send(input logic [31:0] r);
    exp_rx.push_back(r[7:0] & (8'hff >> (2'd3 - cfg[1:0])));
    wr(`UBTX_ADDR_TX_HOLD, {24'h0, r[7:0]});
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (exp_rx.size() > 0 && n < 20000) begin
      @(posedge hclk);
      n++;
    end
    check("drain", exp_rx.size(), 0);
    repeat (40) @(posedge hclk);
    rd(`UBTX_ADDR_LINE_STAT, 32'h60);
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(negedge hclk);
    check("irq", 32'(irq), 32'(e));
  endtask

  // Compares read data and received characters against the oldest notes
  always @(posedge hclk) begin
    if (rd_dp && hreadyout === 1'b1 && exp_rd.size() > 0) begin
      check("hrdata", hrdata, exp_rd.pop_front());
      check("hresp", 32'(hresp), 32'h0);
    end
    if (rx_valid === 1'b1) begin
      check("rx_byte", 32'(rx_byte), 32'(exp_rx.size() ? exp_rx.pop_front() : 8'hxx));
      check("rx_fault", 32'(rx_fault), 32'h0);
    end
  end

  initial begin
    repeat (40000) @(posedge hclk);
    error_cnt++;
    test_done();
  end

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    check("txd_idle", 32'(txd), 32'h1);
    foreach (RA[i]) rd(RA[i], {24'h0, RV[i]});
    wr(`UBTX_ADDR_NONE, 32'h5a);
    rd(`UBTX_ADDR_NONE, 32'h0);
    // Host programs the divisor before any traffic
    wr(`UBTX_ADDR_DIV_HIGH, 32'h09);
    wr(`UBTX_ADDR_DIV_LOW, 32'h00);
    rd(`UBTX_ADDR_DIV_HIGH, 32'h09);
    tick_gap(2304);
    wr(`UBTX_ADDR_DIV_HIGH, 32'h00);
    wr(`UBTX_ADDR_MODEM_CTL, 32'h80);
    wr(`UBTX_ADDR_DIV_LOW, 32'h03);
    tick_gap(12);
    wr(`UBTX_ADDR_MODEM_CTL, 32'h00);
    wr(`UBTX_ADDR_DIV_LOW, 32'h01);
    tick_gap(1);
    // Every data length, stop count, parity sense and sampling rate
    for (int k = 0; k < 8; k++) begin
      cfg <= 6'(k * 13);
      wr(`UBTX_ADDR_LINE_CFG, 32'(6'(k * 13)));
      send(rnd());
      rd(`UBTX_ADDR_LINE_STAT, 32'h20);
      send(rnd());
      drain();
    end
    cfg <= 6'h03;
    wr(`UBTX_ADDR_LINE_CFG, 32'h03);
    wr(`UBTX_ADDR_IRQ_SRC, 32'h06);
    wr(`UBTX_ADDR_IRQ_EN, 32'h02);
    irq_is(1'b0);
    send(rnd());
    irq_is(1'b1);
    drain();
    rd(`UBTX_ADDR_IRQ_SRC, 32'h06);
    wr(`UBTX_ADDR_IRQ_EN, 32'h00);
    irq_is(1'b0);
    wr(`UBTX_ADDR_IRQ_EN, 32'h04);
    irq_is(1'b1);
    wr(`UBTX_ADDR_IRQ_SRC, 32'h06);
    irq_is(1'b0);
    rd(`UBTX_ADDR_IRQ_SRC, 32'h00);
    // Back-to-back bytes through the FIFO leave without gaps
    wr(`UBTX_ADDR_TX_TRIG, 32'h04);
    wr(`UBTX_ADDR_FIFO_CTL, 32'h01);
    for (int k = 0; k < 8; k++) send(rnd());
    rd(`UBTX_ADDR_LINE_STAT, 32'h00);
    drain();
    // Level fell below the trigger once, then the shifter emptied
    rd(`UBTX_ADDR_IRQ_SRC, 32'h06);
    test_done();
  end
endmodule
